/* File: hw/acc_pkg.sv */
package acc_pkg;
    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_SPK_CTRL = 30'h0b000168;
    localparam logic [29:0] IDX_SPK_DIV = 30'h0b00016e;
    localparam logic [29:0] IDX_MIC_DATA = 30'h0b000170;
    localparam logic [29:0] IDX_MIC_CTRL = 30'h0b000172;

    // control register field positions
    localparam int BIT_REF_CONNECT = 15;
    localparam int BIT_RUNNING = 3;
    localparam int BIT_STOP_PAGE = 1;
    localparam int BIT_ADC_REQ = 0;

    // reset values
    localparam logic [15:0] RST_SPK_DIV = 16'h08dc;
    localparam logic [9:0] RST_MIC_DATA = 10'h200;
    localparam logic RST_REF_CONNECT = 1'b0;
    localparam logic RST_STOP_PAGE = 1'b0;

    // sample width and buffer depth
    localparam int SAMPLE_W = 10;
    localparam int BUF_DEPTH = 32;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register select codes
    typedef enum logic [2:0] {
        ACC_SEL_NONE,
        ACC_SEL_SPK_CTRL,
        ACC_SEL_SPK_DIV,
        ACC_SEL_MIC_DATA,
        ACC_SEL_MIC_CTRL
    } acc_sel_e;
endpackage

/* File: hw/acc_top.sv */
// Contract
// R01 - speaker bit 15 connects D/A reference
// R02 - speaker bit 3 reads running state
// R03 - speaker running valid only when enabled
// R04 - speaker bit 1 selects DMA stop page
// R05 - reserved bits read zero, writes ignored
// R06 - divisor equals clock over sample rate
// R07 - software keeps rate at most 50 ksps
// R08 - mic register holds ADC sample, forwards
// R09 - mic data writes only when enabled
// R10 - mic disable reloads mid-scale 0x0200
// R11 - mic bit 15 connects A/D reference
// R12 - mic bit 3 running, valid when enabled
// R13 - mic bit 1 selects DMA stop page
// R14 - mic bit 0 shows ADC use request
// R15 - audio unit wins ADC arbitration ties
// R16 - speaker enable gates speaker and DMA
// R17 - mic enable gates microphone and DMA
// R18 - counter issues conversion per divisor cycles
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

module acc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic clear_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready_out = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_data_out = mem[rd_ptr_r];

    // storage array, written on push
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_in;
        end
    end

    // pointers and fill count
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || clear_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

module acc_top (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // block enables from the sequencer enable register
    input wire logic spk_block_enable_in,
    input wire logic mic_block_enable_in,
    // D/A side
    output logic dac_reference_connect_out,
    output logic dac_convert_out,
    output logic spk_dma_enable_out,
    output logic spk_dma_stop_page_sel_out,
    // A/D side and shared converter arbitration
    output logic adc_reference_connect_out,
    input wire logic mic_conv_start_in,
    input wire logic panel_adc_request_in,
    output logic adc_grant_audio_out,
    output logic adc_grant_panel_out,
    input wire logic [9:0] adc_sample_in,
    input wire logic adc_sample_valid_in,
    output logic adc_sample_ready_out,
    // microphone DMA buffer stream
    output logic mic_dma_enable_out,
    output logic mic_dma_stop_page_sel_out,
    output logic [9:0] mic_dma_data_out,
    output logic mic_dma_valid_out,
    input wire logic mic_dma_ready_in
);
    // map a byte address onto a register select code
    function automatic acc_pkg::acc_sel_e decode(input logic [31:0] addr);
        case (addr[31:2])
            acc_pkg::IDX_SPK_CTRL: decode = acc_pkg::ACC_SEL_SPK_CTRL;
            acc_pkg::IDX_SPK_DIV: decode = acc_pkg::ACC_SEL_SPK_DIV;
            acc_pkg::IDX_MIC_DATA: decode = acc_pkg::ACC_SEL_MIC_DATA;
            acc_pkg::IDX_MIC_CTRL: decode = acc_pkg::ACC_SEL_MIC_CTRL;
            default: decode = acc_pkg::ACC_SEL_NONE;
        endcase
        if (addr[1:0] != 2'b00) begin
            decode = acc_pkg::ACC_SEL_NONE; // unaligned
        end
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    // bus state
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [31:0] aw_addr_r, w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    // register state
    logic dac_ref_r, spk_page_r, adc_ref_r, mic_page_r;
    logic mic_pending_r, adc_req_r, dac_conv_r, spk_run_r;
    logic [15:0] spk_div_r, spk_cnt_r;
    logic [9:0] mic_data_r;

    // decoded selects and strobes
    acc_pkg::acc_sel_e wsel;
    acc_pkg::acc_sel_e rsel;
    logic do_write, do_read, wr_spk_ctrl, wr_spk_div, wr_mic_data, wr_mic_ctrl;
    logic [15:0] spk_ctrl_rd, mic_ctrl_rd, rd_word;
    logic [15:0] spk_ctrl_new, mic_ctrl_new, spk_div_new, mic_data_new;
    logic spk_last, sample_take, fifo_in_ready, fifo_push, mic_running;

    // bus handshakes: one write and one read in flight
    assign s_axi_awready_out = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready_out = ~w_hold_r & ~bvalid_r;
    assign s_axi_arready_out = ~rvalid_r;
    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rresp_out = rresp_r;
    assign s_axi_rdata_out = rdata_r;

    // write decode once both address and data are held
    assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    assign do_read = s_axi_arvalid_in & ~rvalid_r;
    assign wsel = decode(aw_addr_r);
    assign rsel = decode(s_axi_araddr_in);
    assign wr_spk_ctrl = do_write & (wsel == acc_pkg::ACC_SEL_SPK_CTRL);
    assign wr_spk_div = do_write & (wsel == acc_pkg::ACC_SEL_SPK_DIV);
    assign wr_mic_data = do_write & (wsel == acc_pkg::ACC_SEL_MIC_DATA);
    assign wr_mic_ctrl = do_write & (wsel == acc_pkg::ACC_SEL_MIC_CTRL);
    assign spk_ctrl_new = merge16(spk_ctrl_rd, w_data_r, w_strb_r);
    assign mic_ctrl_new = merge16(mic_ctrl_rd, w_data_r, w_strb_r);
    assign spk_div_new = merge16(spk_div_r, w_data_r, w_strb_r);
    assign mic_data_new = merge16({6'h00, mic_data_r}, w_data_r, w_strb_r);

    // read views; reserved bits stay zero
    assign mic_running = mic_block_enable_in & adc_ref_r; // R12
    always_comb begin
        spk_ctrl_rd = 16'h0000; // R05
        spk_ctrl_rd[acc_pkg::BIT_REF_CONNECT] = dac_ref_r; // R01
        spk_ctrl_rd[acc_pkg::BIT_RUNNING] = spk_run_r; // R02
        spk_ctrl_rd[acc_pkg::BIT_STOP_PAGE] = spk_page_r; // R04
        mic_ctrl_rd = 16'h0000; // R05
        mic_ctrl_rd[acc_pkg::BIT_REF_CONNECT] = adc_ref_r; // R11
        mic_ctrl_rd[acc_pkg::BIT_RUNNING] = mic_running; // R12
        mic_ctrl_rd[acc_pkg::BIT_STOP_PAGE] = mic_page_r; // R13
        mic_ctrl_rd[acc_pkg::BIT_ADC_REQ] = adc_req_r; // R14
    end

    // read multiplexer
    always_comb begin
        case (rsel)
            acc_pkg::ACC_SEL_SPK_CTRL: rd_word = spk_ctrl_rd;
            acc_pkg::ACC_SEL_SPK_DIV: rd_word = spk_div_r;
            acc_pkg::ACC_SEL_MIC_DATA: rd_word = {6'h00, mic_data_r}; // R05
            acc_pkg::ACC_SEL_MIC_CTRL: rd_word = mic_ctrl_rd;
            default: rd_word = 16'h0000;
        endcase
    end

    // write address and data capture, in either order
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 32'h00000000;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_strb_r <= s_axi_wstrb_in;
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // write response, error on unmapped address
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bvalid_r <= 1'b0;
            bresp_r <= acc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wsel == acc_pkg::ACC_SEL_NONE) ?
                       acc_pkg::RESP_SLVERR : acc_pkg::RESP_OKAY;
        end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
        end
    end

    // read data and response
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rvalid_r <= 1'b0;
            rresp_r <= acc_pkg::RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_word};
            rresp_r <= (rsel == acc_pkg::ACC_SEL_NONE) ?
                       acc_pkg::RESP_SLVERR : acc_pkg::RESP_OKAY;
        end else if (s_axi_rready_in) begin
            rvalid_r <= 1'b0;
        end
    end

    // control bits; only documented fields are stored
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            dac_ref_r <= acc_pkg::RST_REF_CONNECT;
            spk_page_r <= acc_pkg::RST_STOP_PAGE;
            adc_ref_r <= acc_pkg::RST_REF_CONNECT;
            mic_page_r <= acc_pkg::RST_STOP_PAGE;
            spk_div_r <= acc_pkg::RST_SPK_DIV;
        end else begin
            if (wr_spk_ctrl) begin
                dac_ref_r <= spk_ctrl_new[acc_pkg::BIT_REF_CONNECT]; // R01
                spk_page_r <= spk_ctrl_new[acc_pkg::BIT_STOP_PAGE]; // R04
            end
            if (wr_mic_ctrl) begin
                adc_ref_r <= mic_ctrl_new[acc_pkg::BIT_REF_CONNECT]; // R11
                mic_page_r <= mic_ctrl_new[acc_pkg::BIT_STOP_PAGE]; // R13
            end
            if (wr_spk_div) begin
                spk_div_r <= spk_div_new; // R06
            end
        end
    end

    // converter reference and DMA control levels
    assign dac_reference_connect_out = dac_ref_r; // R01
    assign adc_reference_connect_out = adc_ref_r; // R11
    assign spk_dma_stop_page_sel_out = spk_page_r; // R04
    assign mic_dma_stop_page_sel_out = mic_page_r; // R13
    assign spk_dma_enable_out = spk_block_enable_in; // R16
    assign mic_dma_enable_out = mic_block_enable_in; // R17

    // rate counter: last cycle of each divisor period
    assign spk_last = (spk_div_r <= 16'h0001) ||
                      (spk_cnt_r == spk_div_r - 16'h0001); // R18

    // speaker conversion timing, stopped while disabled
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !spk_block_enable_in) begin // R16
            spk_cnt_r <= 16'h0000;
            dac_conv_r <= 1'b0;
            spk_run_r <= 1'b0; // R03
        end else begin
            spk_run_r <= 1'b1; // R02
            if (spk_last) begin
                spk_cnt_r <= 16'h0000;
                dac_conv_r <= 1'b1; // R06
            end else begin
                spk_cnt_r <= spk_cnt_r + 16'h0001;
                dac_conv_r <= 1'b0;
            end
        end
    end
    assign dac_convert_out = dac_conv_r; // R18

    // shared converter request and fixed-priority grant
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !mic_block_enable_in) begin // R17
            adc_req_r <= 1'b0;
        end else if (mic_conv_start_in && adc_ref_r) begin
            adc_req_r <= 1'b1; // R14
        end else if (sample_take) begin
            adc_req_r <= 1'b0;
        end
    end
    assign adc_grant_audio_out = adc_req_r; // R15
    assign adc_grant_panel_out = panel_adc_request_in & ~adc_req_r; // R15

    // sample holding register feeding the DMA buffer
    assign adc_sample_ready_out = mic_block_enable_in &
                                  (~mic_pending_r | fifo_in_ready);
    assign sample_take = adc_sample_valid_in & adc_sample_ready_out;
    assign fifo_push = mic_pending_r & fifo_in_ready;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !mic_block_enable_in) begin
            mic_data_r <= acc_pkg::RST_MIC_DATA; // R10
            mic_pending_r <= 1'b0;
        end else if (sample_take) begin
            mic_data_r <= adc_sample_in; // R08
            mic_pending_r <= 1'b1; // set wins over the push
        end else begin
            if (wr_mic_data) begin
                mic_data_r <= mic_data_new[9:0]; // R09
            end
            if (fifo_push) begin
                mic_pending_r <= 1'b0;
            end
        end
    end

    // microphone DMA buffer, flushed while disabled
    acc_fifo #(
        .WIDTH(acc_pkg::SAMPLE_W),
        .DEPTH(acc_pkg::BUF_DEPTH)
    ) u_mic_fifo (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(~mic_block_enable_in), // R17
        .in_data_in(mic_data_r), // R08
        .in_valid_in(mic_pending_r),
        .in_ready_out(fifo_in_ready),
        .out_data_out(mic_dma_data_out),
        .out_valid_out(mic_dma_valid_out),
        .out_ready_in(mic_dma_ready_in)
    );
endmodule

/* File: verif/acc_monitor.sv */
`timescale 1ns/1ps
module acc_monitor (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic spk_block_enable_in,
    input wire logic mic_block_enable_in,
    input wire logic spk_dma_enable_out,
    input wire logic mic_dma_enable_out,
    input wire logic dac_convert_out,
    input wire logic panel_adc_request_in,
    input wire logic adc_grant_audio_out,
    input wire logic adc_grant_panel_out,
    input wire logic adc_sample_valid_in,
    input wire logic adc_sample_ready_out,
    input wire logic mic_dma_valid_out,
    input wire logic mic_dma_ready_in,
    input wire logic [9:0] mic_dma_data_out,
    input wire logic s_axi_rvalid_out,
    input wire logic [31:0] s_axi_rdata_out
);
    // all checks on the one clock
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    spk_dma_gate_a: assert property (
        spk_dma_enable_out == spk_block_enable_in)
        else $error("speaker dma enable differs");
    mic_dma_gate_a: assert property (
        mic_dma_enable_out == mic_block_enable_in)
        else $error("mic dma enable differs");
    audio_wins_a: assert property (
        adc_grant_audio_out |-> !adc_grant_panel_out)
        else $error("panel granted over audio");
    panel_grant_a: assert property (
        panel_adc_request_in && !adc_grant_audio_out |-> adc_grant_panel_out)
        else $error("panel not granted");
    spk_off_quiet_a: assert property (
        !spk_block_enable_in ##1 !spk_block_enable_in |-> !dac_convert_out)
        else $error("spk off convert");
    mic_off_ready_a: assert property (
        !mic_block_enable_in |-> !adc_sample_ready_out)
        else $error("mic off ready");
    mic_flush_a: assert property (
        !mic_block_enable_in [*2] |-> !mic_dma_valid_out && !adc_grant_audio_out)
        else $error("mic state kept while off");
    req_clear_a: assert property (
        adc_grant_audio_out && adc_sample_valid_in && adc_sample_ready_out
        |=> !adc_grant_audio_out)
        else $error("request kept");
    dma_hold_a: assert property (
        mic_dma_valid_out && !mic_dma_ready_in && mic_block_enable_in
        ##1 mic_block_enable_in |-> mic_dma_valid_out && $stable(mic_dma_data_out))
        else $error("dma word moved");
    rd_upper_a: assert property (
        s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
        else $error("upper read bits set");

    // main scenarios
    cover property (dac_convert_out);
    cover property (adc_grant_audio_out && panel_adc_request_in);
    cover property (!adc_sample_ready_out && mic_block_enable_in);
endmodule

bind acc_top acc_monitor u_mon (.*);

/* File: verif/acc_conv_model.sv */
`timescale 1ns/1ps
module acc_conv_model (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic send_in,
    input wire logic stall_in,
    input wire logic adc_sample_ready_in,
    output logic [9:0] adc_sample_out,
    output logic adc_sample_valid_out,
    output logic mic_dma_ready_out
);
    // converter: hold a sample until taken, scramble idle line
    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            adc_sample_valid_out <= 1'b0;
            adc_sample_out <= 10'h000;
        end else if (adc_sample_valid_out && adc_sample_ready_in) begin
            adc_sample_valid_out <= 1'b0;
            adc_sample_out <= ~adc_sample_out;
        end else if (send_in && !adc_sample_valid_out) begin
            adc_sample_valid_out <= 1'b1;
            adc_sample_out <= 10'($urandom);
        end else if (!adc_sample_valid_out) begin
            adc_sample_out <= ~adc_sample_out;
        end
    end
    // dma sink: stalls on command, otherwise slow at random
    always @(posedge sys_clk_in) begin
        mic_dma_ready_out <= !stall_in && ($urandom_range(3) != 0);
    end
endmodule

/* File: verif/tb_audio_converter_control.sv */
`timescale 1ns/1ps
module tb_audio_converter_control;
    localparam logic [31:0] A_SC = {acc_pkg::IDX_SPK_CTRL, 2'b00};
    localparam logic [31:0] A_DV = {acc_pkg::IDX_SPK_DIV, 2'b00};
    localparam logic [31:0] A_MD = {acc_pkg::IDX_MIC_DATA, 2'b00};
    localparam logic [31:0] A_MC = {acc_pkg::IDX_MIC_CTRL, 2'b00};
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in;
    logic [31:0] s_axi_rdata_out, d;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
    logic s_axi_rready_in, spk_block_enable_in, mic_block_enable_in;
    logic dac_reference_connect_out, dac_convert_out, spk_dma_enable_out;
    logic spk_dma_stop_page_sel_out, adc_reference_connect_out;
    logic mic_conv_start_in, panel_adc_request_in, adc_grant_audio_out;
    logic adc_grant_panel_out, adc_sample_valid_in, adc_sample_ready_out;
    logic mic_dma_enable_out, mic_dma_stop_page_sel_out;
    logic mic_dma_valid_out, mic_dma_ready_in, send, stall;
    logic [9:0] adc_sample_in, mic_dma_data_out, last;
    logic [9:0] q[$];
    int err_total = 0;
    int tests_run = 0;
    int pushes = 0;
    int g, dv;

    always #25 sys_clk_in = ~sys_clk_in;
    acc_top dut (.*);
    acc_conv_model u_model (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .send_in(send),
        .stall_in(stall),
        .adc_sample_ready_in(adc_sample_ready_out),
        .adc_sample_out(adc_sample_in),
        .adc_sample_valid_out(adc_sample_valid_in),
        .mic_dma_ready_out(mic_dma_ready_in)
    );

    task automatic conclude;
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hang;
        err_total++;
        $display("MISMATCH t=%0t wait limit hit", $time);
        conclude;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t smp=%h exp=%h", $time, got, exp);
        end
    endtask
    // one write; channels released as each is taken
    task automatic wr(input logic [31:0] a, v, output logic [1:0] rs);
        int n = 0;
        logic ta, tw, tb;
        @(posedge sys_clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= v;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(negedge sys_clk_in);
            ta = s_axi_awvalid_in && s_axi_awready_out;
            tw = s_axi_wvalid_in && s_axi_wready_out;
            tb = s_axi_bvalid_out;
            rs = s_axi_bresp_out;
            @(posedge sys_clk_in);
            if (ta) s_axi_awvalid_in <= 1'b0;
            if (tw) s_axi_wvalid_in <= 1'b0;
            n++;
        end while (!tb && n < 100);
        s_axi_bready_in <= 1'b0;
        if (!tb) hang;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int n = 0;
        logic ta, tr;
        @(posedge sys_clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(negedge sys_clk_in);
            ta = s_axi_arvalid_in && s_axi_arready_out;
            tr = s_axi_rvalid_out;
            v = s_axi_rdata_out;
            rs = s_axi_rresp_out;
            @(posedge sys_clk_in);
            if (ta) s_axi_arvalid_in <= 1'b0;
            n++;
        end while (!tr && n < 100);
        s_axi_rready_in <= 1'b0;
        if (!tr) hang;
    endtask
    task automatic wrc(input logic [31:0] a, v);
        wr(a, v, r);
        chk(32'(r), 32'(acc_pkg::RESP_OKAY));
    endtask
    task automatic rdc(input logic [31:0] a, exp);
        rd(a, d, r);
        chk(32'(r), 32'(acc_pkg::RESP_OKAY));
        chk(d, exp);
    endtask
    // cycles from one conversion pulse to the next
    task automatic gap(output int c);
        repeat (2) begin
            c = 0;
            do begin
                @(negedge sys_clk_in);
                c++;
            end while (!dac_convert_out && c < 3000);
        end
        if (c >= 3000) hang;
    endtask
    task automatic drain;
        int n = 0;
        while (q.size() > 0 && n < 1000) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n >= 1000) hang;
        @(posedge sys_clk_in);
    endtask

    // scoreboard: note taken samples, compare words leaving to dma
    always @(negedge sys_clk_in) begin
        if (!sys_rst_in && adc_sample_valid_in && adc_sample_ready_out) begin
            q.push_back(adc_sample_in);
            last = adc_sample_in;
            pushes++;
        end
        if (!sys_rst_in && mic_dma_valid_out && mic_dma_ready_in) begin
            if (q.size() == 0) chk(32'h0, 32'h1);
            else chk_smp(mic_dma_data_out, q.pop_front());
        end
    end

    initial begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'h0;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = 96'h0;
        s_axi_wstrb_in = 4'hf;
        {spk_block_enable_in, mic_block_enable_in} = 2'h0;
        {mic_conv_start_in, panel_adc_request_in, send, stall} = 4'h0;
        void'($urandom(80400));
        repeat (16) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        // reset values, unmapped place refused
        rdc(A_SC, 32'h0);
        rdc(A_DV, {16'h0, acc_pkg::RST_SPK_DIV});
        rdc(A_MD, 32'h200);
        rdc(A_MC, 32'h0);
        rd(A_SC + 32'h4, d, r);
        chk(32'(r), 32'(acc_pkg::RESP_SLVERR));
        wr(A_SC + 32'h4, 32'hffff, r);
        chk(32'(r), 32'(acc_pkg::RESP_SLVERR));
        $display("test reset done");
        // writable bits stick, reserved and status bits stay zero
        wrc(A_SC, 32'hffffffff);
        rdc(A_SC, 32'h8002);
        chk(32'({dac_reference_connect_out, spk_dma_stop_page_sel_out}), 3);
        wrc(A_MC, 32'hffff);
        rdc(A_MC, 32'h8002);
        chk(32'({adc_reference_connect_out, mic_dma_stop_page_sel_out}), 3);
        wrc(A_MC, 32'h8000);
        chk(32'(mic_dma_stop_page_sel_out), 0);
        wrc(A_MD, 32'h155);
        rdc(A_MD, 32'h200);
        $display("test control bits done");
        // debug write with mic on, reload when switched off
        mic_block_enable_in <= 1'b1;
        rdc(A_MC, 32'h8008);
        wrc(A_MD, 32'hffff);
        rdc(A_MD, 32'h3ff);
        mic_block_enable_in <= 1'b0;
        rdc(A_MD, 32'h200);
        rdc(A_MC, 32'h8000);
        $display("test mic data done");
        // speaker pacing at the 50 ksps limit and slower
        for (int i = 0; i < 2; i++) begin
            dv = (i == 0) ? 400 : $urandom_range(900, 401);
            spk_block_enable_in <= 1'b0;
            wrc(A_DV, 32'(dv));
            rdc(A_DV, 32'(dv));
            rdc(A_SC, 32'h8002);
            spk_block_enable_in <= 1'b1;
            gap(g);
            chk(32'(g), 32'(dv));
            rdc(A_SC, 32'h800a);
        end
        $display("test speaker done");
        // audio request beats a panel request
        mic_block_enable_in <= 1'b1;
        panel_adc_request_in <= 1'b1;
        @(posedge sys_clk_in);
        mic_conv_start_in <= 1'b1;
        @(posedge sys_clk_in);
        mic_conv_start_in <= 1'b0;
        @(negedge sys_clk_in);
        chk(32'({adc_grant_audio_out, adc_grant_panel_out}), 2);
        rdc(A_MC, 32'h8009);
        pushes = 0;
        send <= 1'b1;
        @(posedge sys_clk_in);
        send <= 1'b0;
        repeat (100) if (pushes == 0) @(negedge sys_clk_in);
        if (pushes == 0) hang;
        @(negedge sys_clk_in);
        chk(32'({adc_grant_audio_out, adc_grant_panel_out}), 1);
        rdc(A_MC, 32'h8008);
        rdc(A_MD, {22'h0, last});
        panel_adc_request_in <= 1'b0;
        drain;
        $display("test arbitration done");
        // fill buffer against a stalled sink, then drain it
        stall <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        pushes = 0;
        send <= 1'b1;
        repeat (500) if (adc_sample_ready_out) @(negedge sys_clk_in);
        chk(32'(pushes), 32'(acc_pkg::BUF_DEPTH + 1));
        @(posedge sys_clk_in);
        send <= 1'b0;
        stall <= 1'b0;
        drain;
        chk(32'(q.size()), 0);
        mic_block_enable_in <= 1'b0;
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk(32'({mic_dma_valid_out, mic_dma_enable_out}), 0);
        $display("test buffer done");
        conclude;
    end
endmodule
